// [verilog/debug_channel_jtag_control.v]
// Debug mailbox, JTAG disable guard and JTAG reset flag
// Function
// - CPU write stores mailbox byte and sets dirty flag together.
// - Mailbox read gives low seven bits with dirty flag as MSB.
// - Mailbox reached only with debug fuse and debugger access enabled.
// - Mailbox at I/O 0x22, data space 0x42.
// - Data-space address is I/O offset plus 0x20; I/O up to 0x3F.
// - Extended space from 0x60 reached only by load and store.
// - Control/status at I/O 0x34, data 0x54, reset 0x20.
// - JTAG enabled only if disable bit low and enable fuse programmed.
// - Disable bit changes only on same value written twice in four cycles.
// - JTAG reset flag set on reset from scan reset instruction.
// - JTAG reset flag cleared by power-on reset or written zero.
`timescale 1ns/1ns
`include "dbg_ctrl_map.vh"
module debug_channel_jtag_control (
  input wire i_sys_clk,
  input wire i_srst,
  input wire i_por,
  input wire i_cpu_is_io,
  input wire [7:0] i_cpu_addr,
  input wire i_cpu_wr,
  input wire i_cpu_rd,
  input wire [7:0] i_cpu_wdata,
  input wire i_debug_enable_fuse,
  input wire i_jtag_enable_fuse,
  input wire i_dbg_access_en,
  input wire i_dbg_clear_dirty,
  input wire i_scan_reset_event,
  output reg [7:0] o_cpu_rdata,
  output reg o_cpu_hit,
  output reg o_io_passthru,
  output reg [7:0] o_debug_mailbox,
  output reg o_mailbox_dirty_flag,
  output reg o_jtag_port_enable,
  output reg o_jtag_port_disable,
  output reg o_jtag_reset_flag
);
  reg fuse_s1_q;
  reg fuse_s2_q;
  reg jfuse_s1_q;
  reg jfuse_s2_q;
  reg acc_s1_q;
  reg acc_s2_q;
  reg [7:0] mbox_q;
  reg dirty_q;
  reg dis_q;
  reg jrf_q;
  wire sel_mbox;
  wire sel_mcucs;
  wire mapped;
  wire dis_commit;
  wire mbox_route;
  wire dis_wr;

  // Fuse and debugger levels arrive from outside the clock domain
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
      jfuse_s1_q <= 1'b0;
      jfuse_s2_q <= 1'b0;
      acc_s1_q <= 1'b0;
      acc_s2_q <= 1'b0;
    end else begin
      fuse_s1_q <= i_debug_enable_fuse;
      fuse_s2_q <= fuse_s1_q;
      jfuse_s1_q <= i_jtag_enable_fuse;
      jfuse_s2_q <= jfuse_s1_q;
      acc_s1_q <= i_dbg_access_en;
      acc_s2_q <= acc_s1_q;
    end
  end

  io_addr_decode u_dec (
    .i_is_io(i_cpu_is_io),
    .i_addr(i_cpu_addr),
    .o_sel_mailbox(sel_mbox),
    .o_sel_mcucs(sel_mcucs),
    .o_mapped(mapped)
  );

  assign mbox_route = sel_mbox & fuse_s2_q & acc_s2_q;
  assign dis_wr = i_cpu_wr & sel_mcucs;

  timed_write_guard u_guard (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_wr(dis_wr),
    .i_val(i_cpu_wdata[`DISABLE_BIT]),
    .i_cur(dis_q),
    .o_commit(dis_commit)
  );

  // Commit is a cycle late, so the value is held beside the guard
  reg dis_pend_q;
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      mbox_q <= `MAILBOX_RESET;
      dirty_q <= 1'b0;
      dis_q <= 1'b0;
      dis_pend_q <= 1'b0;
    end else begin
      if (i_cpu_wr && mbox_route) begin
        mbox_q <= i_cpu_wdata;
        dirty_q <= 1'b1;
      end else if (i_dbg_clear_dirty) begin
        dirty_q <= 1'b0;
      end
      if (dis_wr) begin
        dis_pend_q <= i_cpu_wdata[`DISABLE_BIT];
      end
      if (dis_commit) begin
        dis_q <= dis_pend_q;
      end
    end
  end

  // Flag survives ordinary reset; only power-on reset or a zero written to its bit clears it
  always @(posedge i_sys_clk) begin
    if (i_por) begin
      jrf_q <= 1'b0;
    end else if (i_scan_reset_event) begin
      jrf_q <= 1'b1;
    end else if (dis_wr && !i_cpu_wdata[`JRF_BIT]) begin
      jrf_q <= 1'b0;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_cpu_rdata <= 8'h00;
      o_cpu_hit <= 1'b0;
      o_io_passthru <= 1'b0;
      o_debug_mailbox <= `MAILBOX_RESET;
      o_mailbox_dirty_flag <= 1'b0;
      o_jtag_port_enable <= 1'b0;
      o_jtag_port_disable <= 1'b0;
      o_jtag_reset_flag <= 1'b0;
    end else begin
      o_cpu_hit <= (i_cpu_rd | i_cpu_wr) & (mbox_route | sel_mcucs);
      o_io_passthru <= (i_cpu_rd | i_cpu_wr) & sel_mbox & ~mbox_route;
      if (i_cpu_rd && mbox_route) begin
        o_cpu_rdata <= {dirty_q, mbox_q[6:0]};
      end else if (i_cpu_rd && sel_mcucs) begin
        o_cpu_rdata <= `MCUCS_RESET;
        o_cpu_rdata[`DISABLE_BIT] <= dis_q;
        o_cpu_rdata[`JRF_BIT] <= jrf_q;
      end else begin
        o_cpu_rdata <= 8'h00;
      end
      o_debug_mailbox <= mbox_q;
      o_mailbox_dirty_flag <= dirty_q;
      o_jtag_port_enable <= ~dis_q & jfuse_s2_q;
      o_jtag_port_disable <= dis_q;
      o_jtag_reset_flag <= jrf_q;
    end
  end
endmodule // debug_channel_jtag_control

// [verilog/dbg_ctrl_map.vh]
// Address map, field positions and reset values of the debug control block
`ifndef DBG_CTRL_MAP_VH
`define DBG_CTRL_MAP_VH
`define IO_SPACE_TOP 8'h3f
`define IO_TO_DATA 8'h20
`define EXT_IO_BASE 8'h60
`define MAILBOX_IO 8'h22
`define MAILBOX_DATA 8'h42
`define MCUCS_IO 8'h34
`define MCUCS_DATA 8'h54
`define MCUCS_RESET 8'h20
`define MAILBOX_RESET 8'h00
`define DIRTY_BIT 7
`define DISABLE_BIT 7
`define JRF_BIT 4
`define GUARD_CYCLES 3'h4
`endif

// [verilog/io_addr_decode.v]
// Maps an I/O or data-space address onto the block's register selects
`timescale 1ns/1ns
`include "dbg_ctrl_map.vh"
module io_addr_decode (
  input wire i_is_io,
  input wire [7:0] i_addr,
  output reg o_sel_mailbox,
  output reg o_sel_mcucs,
  output reg o_mapped
);
  reg [7:0] data_addr;
  always @* begin
    data_addr = 8'h00;
    o_sel_mailbox = 1'b0;
    o_sel_mcucs = 1'b0;
    o_mapped = 1'b0;
    if (i_is_io) begin
      if (i_addr <= `IO_SPACE_TOP) begin
        data_addr = i_addr + `IO_TO_DATA;
        o_mapped = 1'b1;
      end
    end else if (i_addr >= `EXT_IO_BASE) begin
      data_addr = i_addr;
      o_mapped = 1'b1;
    end else begin
      data_addr = i_addr;
      o_mapped = 1'b1;
    end
    if (o_mapped && data_addr == `MAILBOX_DATA) begin
      o_sel_mailbox = 1'b1;
    end else if (o_mapped && data_addr == `MCUCS_DATA) begin
      o_sel_mcucs = 1'b1;
    end
  end
endmodule // io_addr_decode

// [verilog/timed_write_guard.v]
// Accepts a new bit value only when written the same way twice in a window
`timescale 1ns/1ns
`include "dbg_ctrl_map.vh"
module timed_write_guard #(
  parameter [2:0] WINDOW = `GUARD_CYCLES
) (
  input wire i_sys_clk,
  input wire i_srst,
  input wire i_wr,
  input wire i_val,
  input wire i_cur,
  output reg o_commit
);
  reg armed_q;
  reg pend_val_q;
  reg [2:0] age_q;
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      armed_q <= 1'b0;
      pend_val_q <= 1'b0;
      age_q <= 3'h0;
      o_commit <= 1'b0;
    end else begin
      o_commit <= 1'b0;
      if (i_wr) begin
        if (armed_q && pend_val_q == i_val && age_q < WINDOW) begin
          o_commit <= 1'b1;
          armed_q <= 1'b0;
        end else begin
          armed_q <= 1'b1;
          pend_val_q <= i_val;
          age_q <= 3'h1;
        end
      end else if (armed_q) begin
        if (age_q >= WINDOW) begin
          armed_q <= 1'b0;
        end else begin
          age_q <= age_q + 3'h1;
        end
      end
    end
  end
endmodule // timed_write_guard

// [test/dbg_partner.sv]
// Debugger model that clears the mailbox dirty flag once it has stayed high a set number of cycles
`timescale 1ns/1ns
module dbg_partner (
  input wire i_sys_clk,
  input wire i_slow,
  input wire i_dirty,
  output reg o_clear
);
  // Counts cycles with the dirty flag high; both registers start at zero
  reg [3:0] wait_q = 4'h0;
  initial o_clear = 1'h0;
  always @(posedge i_sys_clk) begin
    wait_q <= i_dirty ? wait_q + 4'h1 : 4'h0;
    o_clear <= wait_q == (i_slow ? 4'hc : 4'h2);
  end
endmodule // dbg_partner

// [test/debug_channel_jtag_control_sva.sv]
// Checker for the debug mailbox and JTAG control ports
`timescale 1ns/1ns
module dbg_ctrl_sva (
  input wire i_sys_clk,
  input wire i_srst,
  input wire i_por,
  input wire i_cpu_is_io,
  input wire [7:0] i_cpu_addr,
  input wire i_cpu_wr,
  input wire i_cpu_rd,
  input wire [7:0] i_cpu_wdata,
  input wire i_debug_enable_fuse,
  input wire i_dbg_access_en,
  input wire i_scan_reset_event,
  input wire [7:0] o_cpu_rdata,
  input wire o_cpu_hit,
  input wire o_io_passthru,
  input wire [7:0] o_debug_mailbox,
  input wire o_mailbox_dirty_flag,
  input wire o_jtag_port_disable,
  input wire o_jtag_reset_flag
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  wire mb = i_cpu_addr == (i_cpu_is_io ? 8'h22 : 8'h42);
  // Mirror of the two-stage synchronisers on the routing levels
  logic [1:0] fuse_q, acc_q;
  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      fuse_q <= 2'h0;
      acc_q <= 2'h0;
    end else begin
      fuse_q <= {fuse_q[0], i_debug_enable_fuse};
      acc_q <= {acc_q[0], i_dbg_access_en};
    end
  end
  wire rt = fuse_q[1] && acc_q[1];
  wire cs = i_cpu_is_io && i_cpu_addr == 8'h34;
  sequence s_mb_wr;
    i_cpu_wr && mb && rt;
  endsequence
  a_mb_wr_set: assert property (s_mb_wr |-> ##2 o_mailbox_dirty_flag
    && o_debug_mailbox == $past(i_cpu_wdata, 2)) else $error("mb write");
  a_mb_rd_fmt: assert property (i_cpu_rd && mb && rt |=>
    o_cpu_rdata == {o_mailbox_dirty_flag, o_debug_mailbox[6:0]})
    else $error("mb read");
  a_mb_unrouted: assert property (i_cpu_rd && mb && !rt
    |=> o_io_passthru && !o_cpu_hit) else $error("routing");
  a_ext_no_io: assert property (i_cpu_is_io && i_cpu_addr > 8'h3f
    && i_cpu_rd |=> !o_cpu_hit && !o_io_passthru) else $error("ext");
  a_ctrl_hit: assert property (i_cpu_rd && cs |=> o_cpu_hit)
    else $error("ctrl hit");
  a_disable_guard: assert property ($changed(o_jtag_port_disable) |->
    $past(i_cpu_wr && cs, 3)) else $error("disable");
  a_jrf_set: assert property (i_scan_reset_event && !i_por |-> ##2
    o_jtag_reset_flag) else $error("flag set");
  a_jrf_clear: assert property (i_por |-> ##2 !o_jtag_reset_flag)
    else $error("flag clear");
endmodule // dbg_ctrl_sva
bind debug_channel_jtag_control dbg_ctrl_sva u_sva (.*);

// [test/tb_debug_channel_jtag_control.sv]
// Bench for the debug mailbox and JTAG control block
`timescale 1ns/1ns
module tb_debug_channel_jtag_control;
  logic i_sys_clk = 1'h0, i_srst = 1'h1, i_por = 1'h1, i_cpu_is_io = 1'h1;
  logic i_cpu_wr = 1'h0, i_cpu_rd = 1'h0, i_scan_reset_event = 1'h0;
  logic i_debug_enable_fuse = 1'h1, i_jtag_enable_fuse = 1'h1;
  logic i_dbg_access_en = 1'h1;
  logic [7:0] i_cpu_addr = 8'h00, i_cpu_wdata = 8'h00;
  wire [7:0] o_cpu_rdata, o_debug_mailbox;
  wire o_cpu_hit, o_io_passthru, o_mailbox_dirty_flag, i_dbg_clear_dirty;
  wire o_jtag_port_enable, o_jtag_port_disable, o_jtag_reset_flag;
  wire [7:0] st = {4'h0, o_jtag_port_enable, o_jtag_reset_flag, o_cpu_hit,
    o_io_passthru};
  int err_count = 0, checks = 0;
  debug_channel_jtag_control dut (.*);
  dbg_partner peer (.i_sys_clk(i_sys_clk), .i_slow(1'h1),
    .i_dirty(o_mailbox_dirty_flag), .o_clear(i_dbg_clear_dirty));
  always #25 i_sys_clk = ~i_sys_clk;
  task tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #5;
  endtask
  task acc(input logic w, io, input logic [7:0] a, d);
    i_cpu_wr = w;
    i_cpu_rd = !w;
    i_cpu_is_io = io;
    i_cpu_addr = a;
    i_cpu_wdata = d;
    @(posedge i_sys_clk);
    i_cpu_wr <= 1'h0;
    i_cpu_rd <= 1'h0;
    #5;
  endtask
  task chk(input string s, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    give_verdict;
  end
  initial begin
    tick(4);
    i_srst = 1'h0;
    i_por = 1'h0;
    tick(2);
    acc(1'h0, 1'h1, 8'h34, 8'h00);
    chk("ctrl", o_cpu_rdata, 8'h20);
    chk("ctrl st", st, 8'h0a);
    acc(1'h1, 1'h1, 8'h22, 8'ha5);
    acc(1'h0, 1'h1, 8'h22, 8'h00);
    chk("mb rd", o_cpu_rdata, 8'ha5);
    chk("mb out", o_debug_mailbox, 8'ha5);
    chk("dirty", {7'h00, o_mailbox_dirty_flag}, 8'h01);
    tick(20);
    acc(1'h0, 1'h0, 8'h42, 8'h00);
    chk("mb clr", o_cpu_rdata, 8'h25);
    chk("clean", {7'h00, o_mailbox_dirty_flag}, 8'h00);
    $display("mailbox test done");
    i_dbg_access_en = 1'h0;
    tick(3);
    acc(1'h0, 1'h1, 8'h22, 8'h00);
    chk("pass", st, 8'h09);
    i_dbg_access_en = 1'h1;
    acc(1'h0, 1'h1, 8'h62, 8'h00);
    chk("ext", st, 8'h08);
    $display("routing test done");
    acc(1'h1, 1'h1, 8'h34, 8'h80);
    tick(6);
    acc(1'h0, 1'h1, 8'h34, 8'h00);
    chk("one wr", o_cpu_rdata, 8'h20);
    acc(1'h1, 1'h1, 8'h34, 8'h80);
    acc(1'h1, 1'h1, 8'h34, 8'h80);
    tick(4);
    acc(1'h0, 1'h1, 8'h34, 8'h00);
    chk("two wr", o_cpu_rdata, 8'ha0);
    chk("jtag off", st, 8'h02);
    chk("dis", {7'h00, o_jtag_port_disable}, 8'h01);
    i_scan_reset_event = 1'h1;
    tick(1);
    i_scan_reset_event = 1'h0;
    tick(2);
    chk("flag", st, 8'h04);
    acc(1'h1, 1'h1, 8'h34, 8'h80);
    tick(2);
    chk("flag wr", st, 8'h00);
    i_scan_reset_event = 1'h1;
    tick(1);
    i_scan_reset_event = 1'h0;
    tick(2);
    chk("flag again", st, 8'h04);
    i_por = 1'h1;
    tick(1);
    i_por = 1'h0;
    tick(2);
    chk("por clr", st, 8'h00);
    $display("control test done");
    give_verdict;
  end
endmodule // tb_debug_channel_jtag_control
